// ---- include/mvc_pkg.sv ----
/*
  Constants for the interrupt-message, vendor capability and link timer
  override register group: byte offsets, field positions, reset values
  and the message sender states.
  Assumes byte offsets into a configuration space with 32-bit words.
*/
package mvc_pkg;

  // byte offsets
  localparam logic [7:0]  OFS_MSI_CTRL    = 8'h4C;
  localparam logic [7:0]  OFS_MSI_ADDR    = 8'h50;
  localparam logic [7:0]  OFS_MSI_UADDR   = 8'h54;
  localparam logic [7:0]  OFS_MSI_DATA    = 8'h58;
  localparam logic [7:0]  OFS_VEND_HDR    = 8'h64;
  localparam logic [7:0]  OFS_SCRATCH0    = 8'h68;
  localparam logic [7:0]  OFS_SCRATCH1    = 8'h6C;
  localparam logic [7:0]  OFS_TIMERS      = 8'h70;

  // capability header contents
  localparam logic [7:0]  MSI_CAP_ID      = 8'h05;
  localparam logic [7:0]  MSI_NEXT_PTR    = 8'h64;
  localparam logic [7:0]  VEND_CAP_ID     = 8'h09;
  localparam logic [7:0]  VEND_NEXT_PTR   = 8'hB0;
  localparam logic [15:0] VEND_LENGTH     = 16'h0034;
  localparam logic [2:0]  MSI_MULTI_CAP   = 3'h2;

  // field positions
  localparam int MSI_EN_BIT      = 16;
  localparam int MMC_LSB         = 17;
  localparam int MME_LSB         = 20;
  localparam int ADDR64_BIT      = 23;
  localparam int REPLAY_LSB      = 0;
  localparam int REPLAY_EN_BIT   = 12;
  localparam int PM_DIS_BIT      = 13;
  localparam int MSI_DIS_BIT     = 14;
  localparam int ACK_LSB         = 16;
  localparam int ACK_EN_BIT      = 30;
  localparam int VGA_BIT         = 31;

  // reset values
  localparam logic [31:0] SCRATCH0_RST    = 32'h0400_1060;
  localparam logic [31:0] SCRATCH1_RST    = 32'h0000_0800;
  localparam logic        ADDR64_RST      = 1'h1;
  localparam logic        VGA_DEC_RST     = 1'h1;
  localparam logic [11:0] REPLAY_RST      = 12'h000;
  localparam logic [13:0] ACK_RST         = 14'h0000;

  typedef enum logic {MVC_IDLE, MVC_SEND} mvc_msg_state_t;

endpackage : mvc_pkg

// ---- src/mvc_msg_sender.sv ----
/*
  Interrupt message sender: turns a rising interrupt level into one
  memory write request carrying the message data to the message address.
  Assumes the consumer acknowledges each request with a one-cycle ack.
*/
module mvc_msg_sender
  import mvc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        irq,
  input  wire logic        msi_en,
  input  wire logic [29:0] addr_lo,
  input  wire logic [31:0] addr_hi,
  input  wire logic [15:0] data,
  input  wire logic        ack,
  output logic             req,
  output logic [63:0]      addr,
  output logic [15:0]      payload,
  output logic             is64
);

  mvc_msg_state_t state;
  logic           irq_prev;
  logic           pend;
  logic           rise;

  assign rise = irq & ~irq_prev & msi_en;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_prev <= 1'h0;
    else
      irq_prev <= irq;
  end

  // event during a write in flight is kept; set wins over the take
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pend <= 1'h0;
    else if (rise && state == MVC_SEND)
      pend <= 1'h1;
    else if (state == MVC_IDLE)
      pend <= 1'h0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state   <= MVC_IDLE;
      req     <= 1'h0;
      addr    <= 64'h0;
      payload <= 16'h0;
      is64    <= 1'h0;
    end
    else
    begin
      case (state)
        MVC_IDLE:
          if (rise || (pend && msi_en))
          begin
            state   <= MVC_SEND;
            req     <= 1'h1;
            addr    <= {addr_hi, addr_lo, 2'h0};
            payload <= data;
            is64    <= (addr_hi != 32'h0);
          end
        MVC_SEND:
          if (ack)
          begin
            state <= MVC_IDLE;
            req   <= 1'h0;
          end
        default:
        begin
          state <= MVC_IDLE;
          req   <= 1'h0;
        end
      endcase
    end
  end

endmodule : mvc_msg_sender

// ---- src/mvc_cfg_regs.sv ----
/*
  Upstream bridge register group: interrupt-message capability, vendor
  capability header, two test scratch words and the replay / ack latency
  timer overrides with the VGA decode status bit.
  Assumes one configuration access per cycle at most, a management load
  port for default overrides and a link layer that supplies its own
  built-in timer values.
*/
// How it works
// R1: message enable bit 16 gates message writes; when set, legacy interrupt stays quiet.
// R2: 64-bit address capable flag, bit 23, reads 1 after reset.
// R3: message address bits 31:2 writable, bits 1:0 read zero, target of writes.
// R4: writable upper message address, reset zero, forms the high address word.
// R5: vendor capability header reads identifier 09h in its lowest byte.
// R6: vendor capability next pointer reads B0h.
// R7: vendor header bits 31:16 read structure length 0034h.
// R8: writable 12-bit user replay value in bits 11:0, reset zero.
// R9: user replay enable bit 12 selects the user replay value.
// R10: writable 14-bit user ack latency in bits 29:16, reset zero.
// R11: ack latency enable bit 30 selects the user latency value.
// R12: read-only bit 31 reports VGA decode enabled, reads 1.
// R13: management load may replace timer fields, enables and capability disables after reset.
// R14: message capability header reads identifier 05h in its lowest byte.
// R15: message capability next pointer reads 64h.
// R16: enabled interrupt event sends one write of message data to programmed address.
// R17: with an enable clear, the link layer's built-in timer value is used.
module mvc_cfg_regs
  import mvc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic [31:0]      CFG_RDATA,
  output logic             CFG_RVALID,
  input  wire logic        MGMT_WR,
  input  wire logic [7:0]  MGMT_ADDR,
  input  wire logic [31:0] MGMT_WDATA,
  input  wire logic        IRQ,
  input  wire logic        MSG_WR_ACK,
  output logic             MSG_WR_REQ,
  output logic [63:0]      MSG_ADDR,
  output logic [15:0]      MSG_DATA,
  output logic             MSG_IS64,
  output logic             LEGACY_INT,
  input  wire logic [11:0] DEF_REPLAY,
  input  wire logic [13:0] DEF_ACK_LAT,
  output logic [11:0]      REPLAY_LIMIT,
  output logic [13:0]      ACK_LAT_LIMIT,
  output logic             MSI_CAP_OFF,
  output logic             PM_CAP_OFF
);

  logic        msi_en;
  logic [2:0]  mme;
  logic [29:0] addr_lo;
  logic [31:0] addr_hi;
  logic [15:0] msg_data;
  logic [31:0] scratch0;
  logic [31:0] scratch1;
  logic [11:0] replay_val;
  logic        replay_en;
  logic        pm_dis;
  logic        msi_dis;
  logic [13:0] ack_val;
  logic        ack_en;
  logic [31:0] next_rdata;
  logic [31:0] timer_word;
  logic        wr_ctrl;
  logic        wr_timer;
  logic        ld_timer;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = new_w[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic hit(input logic [7:0] ofs);
    return CFG_WR && CFG_ADDR == ofs;
  endfunction : hit

  assign wr_ctrl  = hit(OFS_MSI_CTRL);
  assign wr_timer = hit(OFS_TIMERS);
  assign ld_timer = MGMT_WR && MGMT_ADDR == OFS_TIMERS;

  assign timer_word = {VGA_DEC_RST, ack_en, ack_val, 1'h0, msi_dis, pm_dis, replay_en, replay_val};

  // interrupt message control and address words
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      msi_en   <= 1'h0;
      mme      <= 3'h0;
      addr_lo  <= 30'h0;
      addr_hi  <= 32'h0;
      msg_data <= 16'h0;
    end
    else
    begin
      if (wr_ctrl && CFG_BE[2])
      begin
        msi_en <= CFG_WDATA[MSI_EN_BIT];                                    // [R1]
        mme    <= CFG_WDATA[MME_LSB +: 3];
      end
      if (hit(OFS_MSI_ADDR))
        addr_lo <= 30'(merge({addr_lo, 2'h0}, CFG_WDATA, CFG_BE) >> 2);      // [R3]
      if (hit(OFS_MSI_UADDR))
        addr_hi <= merge(addr_hi, CFG_WDATA, CFG_BE);                      // [R4]
      if (hit(OFS_MSI_DATA))
        msg_data <= 16'(merge({16'h0, msg_data}, CFG_WDATA, CFG_BE));
    end
  end

  // test scratch words
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      scratch0 <= SCRATCH0_RST;
      scratch1 <= SCRATCH1_RST;
    end
    else
    begin
      if (hit(OFS_SCRATCH0))
        scratch0 <= merge(scratch0, CFG_WDATA, CFG_BE);
      if (hit(OFS_SCRATCH1))
        scratch1 <= merge(scratch1, CFG_WDATA, CFG_BE);
    end
  end

  // timer overrides; management load wins over a config write
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      replay_val <= REPLAY_RST;                                             // [R8]
      replay_en  <= 1'h0;
      ack_val    <= ACK_RST;                                                // [R10]
      ack_en     <= 1'h0;
      pm_dis     <= 1'h0;
      msi_dis    <= 1'h0;
    end
    else if (ld_timer)
    begin
      replay_val <= MGMT_WDATA[REPLAY_LSB +: 12];                           // [R13]
      replay_en  <= MGMT_WDATA[REPLAY_EN_BIT];
      pm_dis     <= MGMT_WDATA[PM_DIS_BIT];
      msi_dis    <= MGMT_WDATA[MSI_DIS_BIT];
      ack_val    <= MGMT_WDATA[ACK_LSB +: 14];
      ack_en     <= MGMT_WDATA[ACK_EN_BIT];
    end
    else if (wr_timer)
    begin
      if (CFG_BE[0])
        replay_val[7:0] <= CFG_WDATA[7:0];                                  // [R8]
      if (CFG_BE[1])
      begin
        replay_val[11:8] <= CFG_WDATA[11:8];
        replay_en        <= CFG_WDATA[REPLAY_EN_BIT];
      end
      if (CFG_BE[2])
        ack_val[7:0] <= CFG_WDATA[23:16];                                   // [R10]
      if (CFG_BE[3])
      begin
        ack_val[13:8] <= CFG_WDATA[29:24];
        ack_en        <= CFG_WDATA[ACK_EN_BIT];
      end
    end
  end

  // read mux
  always_comb
  begin
    next_rdata = 32'h0;
    case (CFG_ADDR)
      OFS_MSI_CTRL:
        next_rdata = {8'h0, ADDR64_RST, mme, MSI_MULTI_CAP, msi_en,
                      MSI_NEXT_PTR, MSI_CAP_ID};                            // [R2] [R14] [R15]
      OFS_MSI_ADDR:  next_rdata = {addr_lo, 2'h0};                          // [R3]
      OFS_MSI_UADDR: next_rdata = addr_hi;
      OFS_MSI_DATA:  next_rdata = {16'h0, msg_data};
      OFS_VEND_HDR:  next_rdata = {VEND_LENGTH, VEND_NEXT_PTR, VEND_CAP_ID}; // [R5] [R6] [R7]
      OFS_SCRATCH0:  next_rdata = scratch0;
      OFS_SCRATCH1:  next_rdata = scratch1;
      OFS_TIMERS:    next_rdata = timer_word;                               // [R12]
      default:       next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      CFG_RDATA  <= 32'h0;
      CFG_RVALID <= 1'h0;
    end
    else
    begin
      CFG_RVALID <= CFG_RD;
      if (CFG_RD)
        CFG_RDATA <= next_rdata;
    end
  end

  // effective link timers: user value or built-in fallback
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      REPLAY_LIMIT  <= 12'h0;
      ACK_LAT_LIMIT <= 14'h0;
      PM_CAP_OFF    <= 1'h0;
      MSI_CAP_OFF   <= 1'h0;
    end
    else
    begin
      REPLAY_LIMIT  <= replay_en ? replay_val : DEF_REPLAY;                 // [R9] [R17]
      ACK_LAT_LIMIT <= ack_en ? ack_val : DEF_ACK_LAT;                      // [R11] [R17]
      PM_CAP_OFF    <= pm_dis;
      MSI_CAP_OFF   <= msi_dis;
    end
  end

  // legacy interrupt only while messaging is off
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      LEGACY_INT <= 1'h0;
    else
      LEGACY_INT <= IRQ & ~msi_en;                                          // [R1]
  end

  mvc_msg_sender u_sender (
    .clk     (CLK),
    .rstn    (RSTN),
    .irq     (IRQ),
    .msi_en  (msi_en),                                                      // [R1]
    .addr_lo (addr_lo),                                                     // [R3]
    .addr_hi (addr_hi),                                                     // [R4]
    .data    (msg_data),                                                    // [R16]
    .ack     (MSG_WR_ACK),
    .req     (MSG_WR_REQ),
    .addr    (MSG_ADDR),
    .payload (MSG_DATA),
    .is64    (MSG_IS64)
  );

  a_legacy_quiet: assert property (@(posedge CLK) disable iff (!RSTN) // [R1]
    msi_en |=> !LEGACY_INT)
    else $error("legacy interrupt raised while messaging enabled");

  a_legacy_follow: assert property (@(posedge CLK) disable iff (!RSTN) // [R1]
    !msi_en |=> LEGACY_INT == $past(IRQ))
    else $error("legacy interrupt does not follow the source");

  a_req_holds: assert property (@(posedge CLK) disable iff (!RSTN) // [R16]
    MSG_WR_REQ && !MSG_WR_ACK
      |=> MSG_WR_REQ && $stable(MSG_ADDR) && $stable(MSG_DATA) && $stable(MSG_IS64))
    else $error("message write request dropped or changed before ack");

  a_msg_gated: assert property (@(posedge CLK) disable iff (!RSTN) // [R1]
    $rose(MSG_WR_REQ) |-> $past(msi_en))
    else $error("message write started with messaging disabled");

  a_cap64_flag: assert property (@(posedge CLK) disable iff (!RSTN) // [R2]
    CFG_RVALID && $past(CFG_ADDR) == OFS_MSI_CTRL |-> CFG_RDATA[ADDR64_BIT])
    else $error("64-bit capable flag not set");

  a_msg_target: assert property (@(posedge CLK) disable iff (!RSTN) // [R3] [R4] [R16]
    $rose(MSG_WR_REQ) |-> MSG_ADDR == {$past(addr_hi), $past(addr_lo), 2'h0}
                          && MSG_DATA == $past(msg_data) && MSG_IS64 == ($past(addr_hi) != 32'h0))
    else $error("message write target or data wrong");

  a_vendor_hdr: assert property (@(posedge CLK) disable iff (!RSTN) // [R5] [R6] [R7]
    CFG_RVALID && $past(CFG_ADDR) == OFS_VEND_HDR |-> CFG_RDATA == 32'h0034_B009)
    else $error("vendor capability header wrong");

  a_msi_header: assert property (@(posedge CLK) disable iff (!RSTN) // [R14] [R15]
    CFG_RVALID && $past(CFG_ADDR) == OFS_MSI_CTRL |-> CFG_RDATA[15:0] == 16'h6405)
    else $error("message capability header wrong");

  a_replay_pick: assert property (@(posedge CLK) disable iff (!RSTN) // [R9] [R17]
    ld_timer ##1 $stable(DEF_REPLAY)
      |=> REPLAY_LIMIT == ($past(MGMT_WDATA[REPLAY_EN_BIT], 2) ? $past(MGMT_WDATA[11:0], 2) : $past(DEF_REPLAY)))
    else $error("replay limit source wrong");

  a_ack_pick: assert property (@(posedge CLK) disable iff (!RSTN) // [R11] [R17]
    ld_timer ##1 $stable(DEF_ACK_LAT)
      |=> ACK_LAT_LIMIT == ($past(MGMT_WDATA[ACK_EN_BIT], 2) ? $past(MGMT_WDATA[29:16], 2) : $past(DEF_ACK_LAT)))
    else $error("ack latency limit source wrong");

  a_vga_bit: assert property (@(posedge CLK) disable iff (!RSTN) // [R12]
    CFG_RVALID && $past(CFG_ADDR) == OFS_TIMERS |-> CFG_RDATA[VGA_BIT] && !CFG_RDATA[15])
    else $error("vga decode bit not set");

endmodule : mvc_cfg_regs

// ---- verif/mvc_msg_sink.sv ----
/*
  Message write consumer: accepts each request after a chosen number of
  cycles with a one-cycle acknowledge.
  Assumes the request stays up until it is acknowledged.
*/
module mvc_msg_sink
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       req,
  input  wire logic [3:0] delay,
  output logic            ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_cnt <= 4'h0;
      ack      <= 1'b0;
    end
    else if (req && !ack && wait_cnt >= delay)
    begin
      wait_cnt <= 4'h0;
      ack      <= 1'b1;
    end
    else
    begin
      wait_cnt <= (req && !ack) ? wait_cnt + 4'h1 : 4'h0;
      ack      <= 1'b0;
    end
  end
endmodule : mvc_msg_sink

// ---- verif/msi_vendor_cap_link_timer_regs_bench.sv ----
/*
  Self-checking bench: register reads and writes, management loads,
  timer limits and interrupt messages.
  Assumes mvc_pkg and the message sink model.
*/
module msi_vendor_cap_link_timer_regs_bench
  import mvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RSTN, CFG_WR, CFG_RD, MGMT_WR, IRQ, CFG_RVALID;
  logic        MSG_WR_ACK, MSG_WR_REQ, MSG_IS64, LEGACY_INT, MSI_CAP_OFF, PM_CAP_OFF;
  logic [7:0]  CFG_ADDR, MGMT_ADDR;
  logic [3:0]  CFG_BE, ack_delay;
  logic [31:0] CFG_WDATA, CFG_RDATA, MGMT_WDATA, r, u, t;
  logic [63:0] MSG_ADDR;
  logic [15:0] MSG_DATA;
  logic [11:0] DEF_REPLAY, REPLAY_LIMIT;
  logic [13:0] DEF_ACK_LAT, ACK_LAT_LIMIT;
  logic [80:0] msg_q[$];
  logic [31:0] rd_q[$];
  int          fail_count, n_checks, cycles;

  mvc_cfg_regs dut (.CLK, .RSTN, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_BE, .CFG_WDATA, .CFG_RDATA,
    .CFG_RVALID, .MGMT_WR, .MGMT_ADDR, .MGMT_WDATA, .IRQ, .MSG_WR_ACK, .MSG_WR_REQ, .MSG_ADDR,
    .MSG_DATA, .MSG_IS64, .LEGACY_INT, .DEF_REPLAY, .DEF_ACK_LAT, .REPLAY_LIMIT, .ACK_LAT_LIMIT,
    .MSI_CAP_OFF, .PM_CAP_OFF);
  mvc_msg_sink sink (.clk(CLK), .rstn(RSTN), .req(MSG_WR_REQ), .delay(ack_delay), .ack(MSG_WR_ACK));

  always #5 CLK = ~CLK;

  task automatic check(input string what, input logic [80:0] seen, input logic [80:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done;
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge CLK);
    CFG_WR    <= 1'b1;
    CFG_ADDR  <= a;
    CFG_BE    <= be;
    CFG_WDATA <= d;
    @(posedge CLK);
    CFG_WR    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK);
    CFG_RD   <= 1'b1;
    CFG_ADDR <= a;
    rd_q.push_back(e);
    @(posedge CLK);
    CFG_RD   <= 1'b0;
  endtask : rd

  task automatic irq_rise(input logic en);
    @(posedge CLK);
    IRQ <= 1'b1;
    @(posedge CLK);
    @(negedge CLK);
    check("legacy", LEGACY_INT, !en);
    check("msg req", MSG_WR_REQ, en);
    @(posedge CLK);
    IRQ <= 1'b0;
  endtask : irq_rise

  task automatic lim_check(input logic [31:0] v);
    @(posedge CLK);
    @(negedge CLK);
    check("replay", REPLAY_LIMIT, v[12] ? v[11:0] : DEF_REPLAY);
    check("ack lat", ACK_LAT_LIMIT, v[30] ? v[29:16] : DEF_ACK_LAT);
  endtask : lim_check

  // results are compared where they have settled
  always @(negedge CLK)
  begin
    if (CFG_RVALID === 1'b1)
      check("rdata", CFG_RDATA, rd_q.size() ? rd_q.pop_front() : 32'hDEAD_0000);
    if (MSG_WR_REQ === 1'b1 && MSG_WR_ACK === 1'b1)
      check("msg", {MSG_ADDR, MSG_DATA, MSG_IS64}, msg_q.size() ? msg_q.pop_front() : '1);
  end

  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      test_done();
    end
  end

  initial
  begin
    CLK = 1'b0;
    RSTN = 1'b0;
    {CFG_WR, CFG_RD, MGMT_WR, IRQ, CFG_ADDR, MGMT_ADDR, CFG_BE, CFG_WDATA, MGMT_WDATA} = '0;
    ack_delay = 4'h0;
    void'($urandom(11));
    DEF_REPLAY = 12'($urandom);
    DEF_ACK_LAT = 14'($urandom);
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    lim_check(32'h0);
    rd(OFS_MSI_CTRL, 32'h0084_6405);
    rd(OFS_MSI_ADDR, 32'h0);
    rd(OFS_MSI_UADDR, 32'h0);
    rd(OFS_MSI_DATA, 32'h0);
    rd(OFS_VEND_HDR, 32'h0034_B009);
    rd(OFS_SCRATCH0, SCRATCH0_RST);
    rd(OFS_SCRATCH1, SCRATCH1_RST);
    rd(OFS_TIMERS, 32'h8000_0000);
    rd(8'h60, 32'h0);
    r = $urandom;
    u = $urandom | 32'h1;
    t = $urandom;
    wr(OFS_MSI_CTRL, 4'hF, 32'hFFFF_FFFF);
    wr(OFS_MSI_ADDR, 4'hF, r);
    wr(OFS_MSI_UADDR, 4'hF, u);
    wr(OFS_MSI_DATA, 4'hF, t);
    wr(OFS_VEND_HDR, 4'hF, 32'h0);
    wr(OFS_SCRATCH0, 4'h2, r);
    wr(8'h60, 4'hF, r);
    rd(OFS_MSI_CTRL, 32'h00F5_6405);
    rd(OFS_MSI_ADDR, {r[31:2], 2'h0});
    rd(OFS_MSI_UADDR, u);
    rd(OFS_MSI_DATA, {16'h0, t[15:0]});
    rd(OFS_VEND_HDR, 32'h0034_B009);
    rd(OFS_SCRATCH0, {SCRATCH0_RST[31:16], r[15:8], SCRATCH0_RST[7:0]});
    rd(8'h60, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      ack_delay <= k ? 4'h6 : 4'h0;
      repeat (k + 1)
      begin
        msg_q.push_back({u, r[31:2], 2'h0, t[15:0], 1'b1});
        irq_rise(1'b1);
      end
      repeat (20) @(posedge CLK);
    end
    wr(OFS_MSI_UADDR, 4'hF, 32'h0);
    msg_q.push_back({32'h0, r[31:2], 2'h0, t[15:0], 1'b0});
    irq_rise(1'b1);
    repeat (12) @(posedge CLK);
    wr(OFS_MSI_CTRL, 4'hF, 32'h0);
    irq_rise(1'b0);
    for (int k = 0; k < 2; k++)
    begin
      t = $urandom;
      t[12] = k[0];
      t[30] = k[0];
      wr(OFS_TIMERS, 4'hF, t);
      lim_check(t);
      rd(OFS_TIMERS, {1'b1, t[30:16], 3'h0, t[12:0]});
    end
    t = $urandom;
    @(posedge CLK);
    MGMT_WR    <= 1'b1;
    MGMT_ADDR  <= OFS_TIMERS;
    MGMT_WDATA <= t;
    @(posedge CLK);
    MGMT_WR    <= 1'b0;
    lim_check(t);
    check("msi off", MSI_CAP_OFF, t[14]);
    check("pm off", PM_CAP_OFF, t[13]);
    rd(OFS_TIMERS, {1'b1, t[30:16], 1'b0, t[14:0]});
    repeat (4) @(posedge CLK);
    check("reads left", rd_q.size(), 0);
    check("msgs left", msg_q.size(), 0);
    test_done();
  end
endmodule : msi_vendor_cap_link_timer_regs_bench
